// *** design/rtm_pkg.sv ***
// Shared constants for the remote temperature monitor core
package rtm_pkg;
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CLK_KHZ = 200_000;
	localparam int unsigned NS_PER_MS = 1_000_000;
	localparam int unsigned INTEG_MS = 62;
	localparam int unsigned INTEG_CYCLES = INTEG_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned RATE_MS = 500;
	localparam int unsigned RATE_CYCLES = RATE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned SYNC_FMIN_KHZ = 140;
	localparam int unsigned SYNC_FMAX_KHZ = 400;
	localparam int unsigned SYNC_MIN_CYCLES = (CLK_KHZ + SYNC_FMAX_KHZ - 1) / SYNC_FMAX_KHZ;
	localparam int unsigned SYNC_MAX_CYCLES = CLK_KHZ / SYNC_FMIN_KHZ;
	localparam int unsigned INT_OSC_DIV = 768;
	// Addresses; the own-address default is arbitrary
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic [6:0] SLAVE_ADDR_DEF = 7'h18;
	// Command indices
	localparam logic [7:0] CMD_TEMP = 8'h01;
	localparam logic [7:0] CMD_CFG = 8'h02;
	localparam logic [7:0] CMD_HIGH = 8'h03;
	localparam logic [7:0] CMD_LOW = 8'h04;
	localparam logic [7:0] CMD_CRIT = 8'h05;
	localparam logic [7:0] CMD_ONESHOT = 8'h0f;
	// Reset values
	localparam logic [7:0] CMD_RST = 8'h01;
	localparam logic [7:0] CFG_RST = 8'h02;
	localparam logic [7:0] HIGH_RST = 8'h7f;
	localparam logic [7:0] LOW_RST = 8'hc9;
	localparam logic [7:0] CRIT_RST = 8'h64;
	localparam logic [7:0] TEMP_RST = 8'h00;
	// Configuration bit positions
	localparam int unsigned CFG_MASK_BIT = 7;
	localparam int unsigned CFG_STBY_BIT = 6;
	localparam int unsigned CFG_POL_BIT = 5;
	// Data format
	localparam logic [7:0] TEMP_SAT = 8'h7f;
	localparam logic signed [8:0] HYST_DEG = 9'sh005;
	localparam logic signed [10:0] HALF_DEG_Q = 11'sh002;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// *** design/fan_clk_if.sv ***
// Carrier between the core and the fan clock generator
`timescale 1ns/1ps
`default_nettype none
interface fan_clk_if;
	logic sync_level;
	logic tick;
	logic ext_locked;
	modport gen (input sync_level, output tick, output ext_locked);
	modport core (output sync_level, input tick, input ext_locked);
endinterface
`default_nettype wire

// *** design/sync_bits.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_bits import rtm_pkg::*; #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Pins
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;
	sync_s st;
	sync_s next_st;

	always_comb begin
		next_st.meta = async_i;
		next_st.stable = st.meta;
	end

	// Idle-high reset keeps the bus from seeing a false edge after release
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign sync_o = st.stable;
endmodule
`default_nettype wire

// *** design/fan_clk_gen.sv ***
// Fan PWM clock source: external sync when in range, internal divider when the sync is grounded or too fast
`timescale 1ns/1ps
`default_nettype none
module fan_clk_gen import rtm_pkg::*; #(
	parameter int unsigned OSC_DIV = INT_OSC_DIV
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Core side
	fan_clk_if.gen ifc
);
	localparam int unsigned CW = $clog2(SYNC_MAX_CYCLES + 1);
	localparam int unsigned DW = $clog2(OSC_DIV + 1);
	localparam logic [CW-1:0] MIN_C = CW'(SYNC_MIN_CYCLES);
	localparam logic [CW-1:0] MAX_C = CW'(SYNC_MAX_CYCLES);
	localparam logic [DW-1:0] DIV_M1 = DW'(OSC_DIV - 1);

	typedef struct packed {
		logic sync_d;
		logic [CW-1:0] period;
		logic locked;
		logic [DW-1:0] div;
		logic tick;
	} gen_s;
	gen_s st;
	gen_s next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		next_st.sync_d = ifc.sync_level;
		if (st.div == DIV_M1) begin
			next_st.div = '0;
		end else begin
			next_st.div = st.div + 1'b1;
		end
		// A grounded or too-fast sync never locks, so the divider keeps the fan clocked; a too-slow one relocks at each edge
		if (ifc.sync_level && !st.sync_d) begin
			next_st.period = CW'(1);
			next_st.locked = (st.period >= MIN_C) && (st.period <= MAX_C);
			next_st.tick = next_st.locked;
		end else if (st.period < MAX_C) begin
			next_st.period = st.period + 1'b1;
		end else begin
			next_st.locked = 1'b0;
		end
		if (!st.locked && st.div == DIV_M1) begin
			next_st.tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ifc.tick = st.tick;
	assign ifc.ext_locked = st.locked;
endmodule
`default_nettype wire

// *** design/remote_temp_monitor_smbus.sv ***
// Remote temperature monitor core with SMBus slave, limits and thermostat
`timescale 1ns/1ps
`default_nettype none
module remote_temp_monitor_smbus import rtm_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF,
	parameter int unsigned INTEG_CYC = INTEG_CYCLES,
	parameter int unsigned RATE_CYC = RATE_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// SMBus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Open-drain alert and thermostat pins
	output logic alert_n_o,
	output logic alert_n_oe_o,
	output logic thermostat_out_n_o,
	output logic thermostat_out_n_oe_o,
	// Fan clock sync pin and fan clock output
	input wire logic sync_i,
	output logic fan_clk_o,
	output logic fan_enable_o,
	// Converter front end
	input wire logic [9:0] adc_quarter_i,
	input wire logic adc_overrange_i,
	output logic conv_busy_o
);
	localparam int unsigned IW = $clog2(INTEG_CYC + 1);
	localparam int unsigned RW = $clog2(RATE_CYC + 1);
	localparam logic [IW-1:0] INTEG_M1 = IW'(INTEG_CYC - 1);
	localparam logic [RW-1:0] RATE_M1 = RW'(RATE_CYC - 1);

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX = 5'b00010,
		ST_ACK = 5'b00100,
		ST_TX = 5'b01000,
		ST_TXACK = 5'b10000
	} bus_state_e;

	typedef struct packed {
		bus_state_e bst;
		logic scl_d, sda_d;
		logic [3:0] bitcnt;
		logic [1:0] byte_no;
		logic [7:0] shreg;
		logic rw, ara, sda_oe, pin_low;
		logic [7:0] cmd, cfg, high, low, crit, temp;
		logic eval_pend, high_armed, low_armed, alert_latch, thermostat_out_n_act, alert_oe, thermostat_out_n_oe, busy, oneshot_run;
		logic [IW-1:0] integ;
		logic [RW-1:0] rate;
		logic stby_d, fan_en, fan_clk;
	} core_s;
	core_s st;
	core_s next_st;

	logic [2:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic [7:0] rd_byte;

	fan_clk_if fci();

	sync_bits #(
		.WIDTH(3)
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.async_i({sync_i, sda_i, scl_i}),
		.sync_o(pins_s)
	);

	fan_clk_gen u_fan_clk (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ifc(fci.gen)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign fci.sync_level = pins_s[2];

	function automatic logic ge_s(input logic [7:0] a, input logic [7:0] b);
		return $signed(a) >= $signed(b);
	endfunction

	// Quarter-degree input, offset by half a degree, truncated and saturated
	function automatic logic [7:0] round_q(input logic [9:0] q);
		logic signed [10:0] s;
		s = $signed({q[9], q}) + HALF_DEG_Q;
		if ($signed(s[10:2]) > $signed(9'sh07f)) begin
			return TEMP_SAT;
		end
		return s[9:2];
	endfunction

	// Register read decode; unknown indices read as zero
	always_comb begin
		if (st.cmd == CMD_TEMP) begin
			rd_byte = st.temp;
		end else if (st.cmd == CMD_CFG) begin
			rd_byte = st.cfg;
		end else if (st.cmd == CMD_HIGH) begin
			rd_byte = st.high;
		end else if (st.cmd == CMD_LOW) begin
			rd_byte = st.low;
		end else if (st.cmd == CMD_CRIT) begin
			rd_byte = st.crit;
		end else begin
			rd_byte = 8'h00;
		end
	end

	always_comb begin
		logic scl_rise, scl_fall, start_c, stop_c, eval_now, ara_clr, set_alert, oneshot, stby, conv_done;
		logic [7:0] cmp_t, tx_byte;
		scl_rise = scl_s && !st.scl_d;
		scl_fall = !scl_s && st.scl_d;
		start_c = scl_s && st.scl_d && st.sda_d && !sda_s;
		stop_c = scl_s && st.scl_d && !st.sda_d && sda_s;
		eval_now = 1'b0;
		ara_clr = 1'b0;
		set_alert = 1'b0;
		oneshot = 1'b0;
		stby = st.cfg[CFG_STBY_BIT];
		conv_done = 1'b0;
		cmp_t = st.temp;
		tx_byte = st.ara ? {SLAVE_ADDR, 1'b1} : rd_byte;
		next_st = st;
		next_st.scl_d = scl_s;
		next_st.sda_d = sda_s;

		// SMBus slave
		if (start_c) begin
			next_st.bst = ST_RX;
			next_st.bitcnt = '0;
			next_st.byte_no = '0;
			next_st.sda_oe = 1'b0;
		end else if (stop_c) begin
			next_st.bst = ST_IDLE;
			next_st.sda_oe = 1'b0;
			if (st.eval_pend) begin
				eval_now = 1'b1;
				next_st.eval_pend = 1'b0;
			end
		end else begin
			case (st.bst)
				ST_RX: begin
					if (scl_rise) begin
						next_st.shreg = {st.shreg[6:0], sda_s};
						next_st.bitcnt = st.bitcnt + 1'b1;
					end
					if (scl_fall && st.bitcnt == BITS_PER_BYTE) begin
						next_st.bitcnt = '0;
						next_st.bst = ST_ACK;
						next_st.sda_oe = 1'b1;
						if (st.byte_no != 2'd2) begin
							next_st.byte_no = st.byte_no + 1'b1;
						end
						if (st.byte_no == 2'd0) begin
							next_st.rw = st.shreg[0];
							next_st.ara = (st.shreg[7:1] == ARA_ADDR);
							if (st.shreg[7:1] == SLAVE_ADDR) begin
								next_st.ara = 1'b0;
							end else if (!(st.shreg[7:1] == ARA_ADDR && st.shreg[0] && st.alert_latch)) begin
								next_st.bst = ST_IDLE;
								next_st.sda_oe = 1'b0;
							end
						end else if (st.byte_no == 2'd1) begin
							next_st.cmd = st.shreg;
							oneshot = (st.shreg == CMD_ONESHOT);
						end else begin
							// Extra data bytes rewrite the same register
							if (st.cmd == CMD_CFG) begin
								next_st.cfg = st.shreg;
							end else if (st.cmd == CMD_HIGH) begin
								next_st.high = st.shreg;
								next_st.high_armed = 1'b1;
								next_st.eval_pend = 1'b1;
							end else if (st.cmd == CMD_LOW) begin
								next_st.low = st.shreg;
								next_st.low_armed = 1'b1;
								next_st.eval_pend = 1'b1;
							end else if (st.cmd == CMD_CRIT) begin
								next_st.crit = st.shreg;
								next_st.eval_pend = 1'b1;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						next_st.bitcnt = '0;
						if (st.rw) begin
							next_st.bst = ST_TX;
							next_st.shreg = tx_byte;
							next_st.sda_oe = !tx_byte[7];
						end else begin
							next_st.bst = ST_RX;
							next_st.sda_oe = 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise && st.shreg[7] && !sda_s) begin
						// Lost arbitration on the alert response
						next_st.bst = ST_IDLE;
						next_st.sda_oe = 1'b0;
					end else if (scl_fall) begin
						next_st.shreg = {st.shreg[6:0], 1'b0};
						next_st.bitcnt = st.bitcnt + 1'b1;
						if (st.bitcnt == BITS_PER_BYTE - 4'h1) begin
							next_st.bst = ST_TXACK;
							next_st.sda_oe = 1'b0;
							ara_clr = st.ara;
						end else begin
							next_st.sda_oe = !st.shreg[6];
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						// Master nack ends the read; an ack asks for the byte again
						next_st.bst = sda_s ? ST_IDLE : ST_ACK;
					end
				end
				default: begin
					next_st.bst = ST_IDLE;
					next_st.sda_oe = 1'b0;
				end
			endcase
		end

		// Conversion sequencing
		next_st.stby_d = stby;
		if (stby) begin
			next_st.rate = '0;
		end else if (st.rate == RATE_M1) begin
			next_st.rate = '0;
		end else begin
			next_st.rate = st.rate + 1'b1;
		end
		if (st.busy) begin
			if (stby && !st.oneshot_run) begin
				next_st.busy = 1'b0;
			end else if (st.integ == INTEG_M1) begin
				next_st.busy = 1'b0;
				conv_done = 1'b1;
			end else begin
				next_st.integ = st.integ + 1'b1;
			end
		end else if (oneshot || (!stby && (st.stby_d || st.rate == RATE_M1))) begin
			next_st.busy = 1'b1;
			next_st.integ = '0;
			next_st.oneshot_run = oneshot;
			if (oneshot) begin
				next_st.rate = '0;
			end
		end
		if (conv_done) begin
			cmp_t = adc_overrange_i ? TEMP_SAT : round_q(adc_quarter_i);
			next_st.temp = cmp_t;
			eval_now = 1'b1;
		end

		// Limit comparisons
		if (eval_now) begin
			if (st.high_armed && ge_s(cmp_t, st.high)) begin
				set_alert = 1'b1;
				next_st.high_armed = 1'b0;
			end
			if (st.low_armed && ge_s(st.low, cmp_t)) begin
				set_alert = 1'b1;
				next_st.low_armed = 1'b0;
			end
			if (ge_s(cmp_t, st.crit)) begin
				next_st.thermostat_out_n_act = 1'b1;
			end else if ($signed({cmp_t[7], cmp_t}) <= $signed({st.crit[7], st.crit}) - HYST_DEG) begin
				next_st.thermostat_out_n_act = 1'b0;
			end
		end
		// A new alarm in the clearing cycle keeps the latch set
		next_st.alert_latch = (st.alert_latch && !ara_clr) || set_alert;

		// Pins and fan
		next_st.alert_oe = next_st.alert_latch && !next_st.cfg[CFG_MASK_BIT];
		next_st.thermostat_out_n_oe = next_st.thermostat_out_n_act ^ next_st.cfg[CFG_POL_BIT];
		next_st.fan_en = !next_st.cfg[CFG_STBY_BIT];
		if (!next_st.fan_en) begin
			next_st.fan_clk = 1'b0;
		end else if (fci.tick) begin
			next_st.fan_clk = !st.fan_clk;
		end
		next_st.pin_low = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
			st.bst <= ST_IDLE;
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
			st.cmd <= CMD_RST;
			st.cfg <= CFG_RST;
			st.high <= HIGH_RST;
			st.low <= LOW_RST;
			st.crit <= CRIT_RST;
			st.temp <= TEMP_RST;
			st.high_armed <= 1'b1;
			st.low_armed <= 1'b1;
			st.stby_d <= 1'b1;
			st.fan_en <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign sda_o = st.pin_low;
	assign sda_oe_o = st.sda_oe;
	assign alert_n_o = st.pin_low;
	assign alert_n_oe_o = st.alert_oe;
	assign thermostat_out_n_o = st.pin_low;
	assign thermostat_out_n_oe_o = st.thermostat_out_n_oe;
	assign fan_clk_o = st.fan_clk;
	assign fan_enable_o = st.fan_en;
	assign conv_busy_o = st.busy;
endmodule
`default_nettype wire

// *** verif/rtm_monitor.sv ***
// Concurrent checks on the temperature monitor pins
`timescale 1ns/1ps
`default_nettype none
module rtm_monitor #(
	parameter int unsigned INTEG_CYC = 1000,
	parameter int unsigned RATE_CYC = 2400
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Watched pins
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic alert_n_o,
	input wire logic alert_n_oe_o,
	input wire logic thermostat_out_n_o,
	input wire logic thermostat_out_n_oe_o,
	input wire logic fan_clk_o,
	input wire logic fan_enable_o,
	input wire logic conv_busy_o
);
	int unsigned busy_cnt;
	int unsigned idle_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Idle time is only bounded outside standby, where the rate timer runs
	always_ff @(posedge clk_i) begin
		busy_cnt <= (conv_busy_o && !srst_i) ? busy_cnt + 1 : 0;
		idle_cnt <= (conv_busy_o || !fan_enable_o || srst_i) ? 0 : idle_cnt + 1;
	end
	sequence conv_done_s;
		$fell(conv_busy_o);
	endsequence
	sequence stby_exit_s;
		$rose(fan_enable_o);
	endsequence
	a_sda_only_low: assert property (!sda_o) else $error("data pin driven high");
	a_pins_only_low: assert property (!alert_n_o && !thermostat_out_n_o) else $error("pin driven high");
	a_reset_quiet: assert property ($fell(srst_i) |-> !sda_oe_o && !alert_n_oe_o && !thermostat_out_n_oe_o
		&& !fan_clk_o) else $error("pins active after reset");
	a_fan_off_stby: assert property (!fan_enable_o && !$past(fan_enable_o) |-> !fan_clk_o)
		else $error("fan clock runs in standby");
	// Standby cuts a conversion short, so only ends at full power are timed
	a_conv_length: assert property (conv_done_s ##0 fan_enable_o |-> busy_cnt >= INTEG_CYC - 1
		&& busy_cnt <= INTEG_CYC + 1) else $error("conversion length off");
	a_rate_bound: assert property (idle_cnt <= RATE_CYC) else $error("no conversion within rate");
	a_stby_exit_conv: assert property (stby_exit_s |-> ##[0:4] conv_busy_o)
		else $error("no conversion after standby exit");
	a_sda_turn_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed with clock high");
endmodule
bind remote_temp_monitor_smbus rtm_monitor #(.INTEG_CYC(INTEG_CYC), .RATE_CYC(RATE_CYC)) u_mon (.clk_i(clk_i),
	.srst_i(srst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_n_o(alert_n_o),
	.alert_n_oe_o(alert_n_oe_o), .thermostat_out_n_o(thermostat_out_n_o),
	.thermostat_out_n_oe_o(thermostat_out_n_oe_o), .fan_clk_o(fan_clk_o), .fan_enable_o(fan_enable_o),
	.conv_busy_o(conv_busy_o));
`default_nettype wire

// *** verif/smbus_master_model.sv ***
// Behavioural SMBus master for the bench
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model #(
	parameter real QTR = 31.25
) (
	// Bus pins; a 1 on sda_o releases the line
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Start or repeated start
	task automatic start();
		sda_o = 1'b1;
		#QTR scl_o = 1'b1;
		#QTR sda_o = 1'b0;
		#QTR scl_o = 1'b0;
		#QTR;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		#QTR scl_o = 1'b1;
		#QTR sda_o = 1'b1;
		#QTR;
		#QTR;
	endtask
	// Data moves only while the clock is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		#QTR scl_o = 1'b1;
		#QTR r = sda_i;
		#QTR scl_o = 1'b0;
		#QTR;
	endtask
	// Eight bits MSB first, then the acknowledge clock
	task automatic xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx = {rx[6:0], r};
		end
		bit_io(nack, r);
		ack = !r;
	endtask
endmodule
`default_nettype wire

// *** verif/remote_temp_monitor_smbus_bench.sv ***
// Self-checking bench for the remote temperature monitor core
`timescale 1ns/1ps
`default_nettype none
module remote_temp_monitor_smbus_bench import rtm_pkg::*; ();
	typedef struct packed {logic [9:0] q; logic ovr; logic [7:0] t; logic th;} row_s;
	logic clk_i = 1'b0;
	logic srst = 1'b1;
	logic sync = 1'b0;
	logic ovr = 1'b0;
	logic [9:0] q = 10'h000;
	logic scl, m_sda, sda_oe, sda_w, sda_d, al_d, al_oe, th_d, th_oe, fclk, fen, busy, ack;
	logic [7:0] rx;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	row_s rows [0:13] = '{'{10'h1ff, 1'b0, 8'h7f, 1'b1}, '{10'h1f8, 1'b0, 8'h7e, 1'b1},
		'{10'h184, 1'b0, 8'h61, 1'b1}, '{10'h17c, 1'b0, 8'h5f, 1'b0}, '{10'h190, 1'b0, 8'h64, 1'b1},
		'{10'h065, 1'b0, 8'h19, 1'b0}, '{10'h002, 1'b0, 8'h01, 1'b0}, '{10'h001, 1'b0, 8'h00, 1'b0},
		'{10'h3fe, 1'b0, 8'h00, 1'b0}, '{10'h3fd, 1'b0, 8'hff, 1'b0}, '{10'h39c, 1'b0, 8'he7, 1'b0},
		'{10'h325, 1'b0, 8'hc9, 1'b0}, '{10'h2fc, 1'b0, 8'hbf, 1'b0}, '{10'h000, 1'b1, 8'h7f, 1'b1}};
	always #2.5 clk_i = ~clk_i;
	// Pulled-up data line, low when either side pulls
	assign sda_w = m_sda & ~sda_oe;
	smbus_master_model m (.sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
	remote_temp_monitor_smbus #(.INTEG_CYC(1000), .RATE_CYC(2400)) dut (.clk_i(clk_i), .srst_i(srst),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe), .alert_n_o(al_d), .alert_n_oe_o(al_oe),
		.thermostat_out_n_o(th_d), .thermostat_out_n_oe_o(th_oe), .sync_i(sync), .fan_clk_o(fclk),
		.fan_enable_o(fen), .adc_quarter_i(q), .adc_overrange_i(ovr), .conv_busy_o(busy));
	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xb(input logic [7:0] b);
		m.xfer(b, 1'b1, rx, ack);
		check(ack, 1'b1);
	endtask
	task automatic rcv(input logic [6:0] a, input logic [7:0] exp);
		m.start();
		xb({a, 1'b1});
		m.xfer(8'hff, 1'b1, rx, ack);
		m.stop();
		check(rx, exp);
	endtask
	// Trailing wait lets the compare after stop reach the pins
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		m.start();
		xb({SLAVE_ADDR_DEF, 1'b0});
		xb(cmd);
		xb(d);
		m.stop();
		#50;
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		m.start();
		xb({SLAVE_ADDR_DEF, 1'b0});
		xb(cmd);
		rcv(SLAVE_ADDR_DEF, exp);
	endtask
	task automatic nak(input logic [6:0] a);
		m.start();
		m.xfer({a, 1'b1}, 1'b1, rx, ack);
		m.stop();
		check(ack, 1'b0);
	endtask
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 3000 && busy !== v; i++)
			@(posedge clk_i) #1;
	endtask
	task automatic fan_count(input int per, input int len);
		logic last;
		last = fclk;
		n = 0;
		for (int i = 0; i < len; i++) begin
			@(posedge clk_i) #1;
			sync = (per != 0) && (i % per < per / 2);
			n += int'(fclk !== last);
			last = fclk;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk_i);
		rcv(SLAVE_ADDR_DEF, 8'h00);
		rd(CMD_HIGH, 8'h7f);
		rd(CMD_LOW, 8'hc9);
		rd(CMD_CRIT, 8'h64);
		rd(CMD_CFG, 8'h02);
		$display("test reset values done");
		wr(CMD_HIGH, 8'h50);
		rd(CMD_HIGH, 8'h50);
		wr(8'h07, 8'haa);
		rd(8'h07, 8'h00);
		wr(CMD_HIGH, 8'h7f);
		m.start();
		xb({SLAVE_ADDR_DEF, 1'b0});
		xb(CMD_TEMP);
		m.stop();
		rcv(SLAVE_ADDR_DEF, 8'h00);
		nak(7'h19);
		nak(ARA_ADDR);
		$display("test register access done");
		foreach (rows[i]) begin
			@(posedge clk_i) #1;
			q = rows[i].q;
			ovr = rows[i].ovr;
			wait_busy(1'b1);
			wait_busy(1'b0);
			rcv(SLAVE_ADDR_DEF, rows[i].t);
			check(th_oe, rows[i].th);
		end
		$display("test conversion table done");
		check(al_oe, 1'b1);
		check({5'h00, sda_d, al_d, th_d}, 8'h00);
		rcv(ARA_ADDR, {SLAVE_ADDR_DEF, 1'b1});
		check(al_oe, 1'b0);
		$display("test alert response done");
		@(posedge clk_i) #1;
		q = 10'h065;
		ovr = 1'b0;
		wait_busy(1'b0);
		wait_busy(1'b1);
		rcv(SLAVE_ADDR_DEF, 8'h7f);
		wait_busy(1'b0);
		rcv(SLAVE_ADDR_DEF, 8'h19);
		check(th_oe, 1'b0);
		$display("test read during conversion done");
		wr(CMD_CFG, 8'h42);
		check(fen, 1'b0);
		wr(CMD_CRIT, 8'h10);
		check(th_oe, 1'b1);
		wr(CMD_CRIT, 8'h64);
		check(th_oe, 1'b0);
		check(busy, 1'b0);
		m.start();
		xb({SLAVE_ADDR_DEF, 1'b0});
		xb(CMD_ONESHOT);
		m.stop();
		check(busy, 1'b1);
		wait_busy(1'b0);
		check(busy, 1'b0);
		wr(CMD_CFG, 8'h22);
		check(th_oe, 1'b1);
		wait_busy(1'b1);
		check(busy, 1'b1);
		$display("test standby done");
		fan_count(600, 1800);
		fan_count(600, 3000);
		check(n[7:0], 8'h05);
		fan_count(0, 1536);
		fan_count(0, 3072);
		check(n[7:0], 8'h04);
		$display("test fan clock done");
		wr(CMD_LOW, 8'h20);
		check(al_oe, 1'b1);
		@(posedge clk_i) #1;
		srst = 1'b1;
		repeat (10) @(posedge clk_i);
		#1 srst = 1'b0;
		check(al_oe, 1'b0);
		check(th_oe, 1'b0);
		repeat (4) @(posedge clk_i);
		rcv(SLAVE_ADDR_DEF, 8'h00);
		rd(CMD_LOW, 8'hc9);
		$display("test mid-run reset done");
		close_out();
	end
endmodule
`default_nettype wire
